/* File: verilog/sio_top.v */
// safe i/o routing, pairing and discrepancy supervision
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "sio_defs.vh"
module sio_top #(
  parameter integer DISC_CYCLES = `SIO_DISC_MS * `SIO_CLK_KHZ
) (
  // clock and reset
  input wire clock,
  input wire resetn,
  // register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // safety function results, codes 0x01..0x40 at bits 1..64
  input wire [64:0] func_result,
  input wire [1:0] restart_req,
  // safe input terminals
  input wire [3:0] safe_in_pin,
  // safe output terminals and fault
  output reg [3:0] safe_out_pin,
  output reg io_failure,
  output reg irq
);

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  reg [3:0] in_meta_r;
  reg [3:0] in_r;
  reg [64:0] fn_meta_r;
  reg [64:0] fn_r;
  reg [1:0] rack_meta_r;
  reg [1:0] rack_r;

  // safe input terminals, only the second flop is read
  always @(posedge clock) begin
    if (!resetn) begin
      in_meta_r <= 4'h0;
      in_r <= 4'h0;
    end else begin
      in_meta_r <= safe_in_pin;
      in_r <= in_meta_r;
    end
  end

  // safety function results from the axis monitors
  always @(posedge clock) begin
    if (!resetn) begin
      fn_meta_r <= 65'h0;
      fn_r <= 65'h0;
    end else begin
      fn_meta_r <= func_result;
      fn_r <= fn_meta_r;
    end
  end

  // restart-acknowledge requests of both axes
  always @(posedge clock) begin
    if (!resetn) begin
      rack_meta_r <= 2'h0;
      rack_r <= 2'h0;
    end else begin
      rack_meta_r <= restart_req;
      rack_r <= rack_meta_r;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  reg [7:0] src0_r;
  reg [7:0] src1_r;
  reg [7:0] src2_r;
  reg [7:0] src3_r;
  reg [7:0] psrc0_r;
  reg [7:0] psrc1_r;
  reg [7:0] ctrl_r;
  reg [7:0] mask_r;
  reg [1:0] fail_stat_r;
  reg [1:0] fail_evt_r;

  // ------------------------------------------------------------
  // write strobes per register
  // ------------------------------------------------------------
  wire wr_src0 = reg_wr && (reg_addr == `SIO_A_SRC0);
  wire wr_src1 = reg_wr && (reg_addr == `SIO_A_SRC1);
  wire wr_src2 = reg_wr && (reg_addr == `SIO_A_SRC2);
  wire wr_src3 = reg_wr && (reg_addr == `SIO_A_SRC3);
  wire wr_stat = reg_wr && (reg_addr == `SIO_A_STAT);
  wire wr_psrc0 = reg_wr && (reg_addr == `SIO_A_PSRC0);
  wire wr_psrc1 = reg_wr && (reg_addr == `SIO_A_PSRC1);
  wire wr_ctrl = reg_wr && (reg_addr == `SIO_A_CTRL);
  wire wr_mask = reg_wr && (reg_addr == `SIO_A_MASK);
  wire [1:0] stat_clr = wr_stat ? reg_wdata[`SIO_S_FAIL1:`SIO_S_FAIL0] : 2'h0;

  // ------------------------------------------------------------
  // source selection registers, volatile
  // ------------------------------------------------------------

  // output 1 single code; reset restores the default
  always @(posedge clock) begin
    if (!resetn) begin
      src0_r <= `SIO_RST_ON;
    end else if (wr_src0) begin
      src0_r <= reg_wdata;
    end
  end

  // output 2 single code
  always @(posedge clock) begin
    if (!resetn) begin
      src1_r <= `SIO_RST_ON;
    end else if (wr_src1) begin
      src1_r <= reg_wdata;
    end
  end

  // output 3 single code, the only one off after reset
  always @(posedge clock) begin
    if (!resetn) begin
      src2_r <= `SIO_RST_OFF;
    end else if (wr_src2) begin
      src2_r <= reg_wdata;
    end
  end

  // output 4 single code
  always @(posedge clock) begin
    if (!resetn) begin
      src3_r <= `SIO_RST_ON;
    end else if (wr_src3) begin
      src3_r <= reg_wdata;
    end
  end

  // pair 1+2 code, off after reset
  always @(posedge clock) begin
    if (!resetn) begin
      psrc0_r <= `SIO_RST_OFF;
    end else if (wr_psrc0) begin
      psrc0_r <= reg_wdata;
    end
  end

  // pair 3+4 code, off after reset
  always @(posedge clock) begin
    if (!resetn) begin
      psrc1_r <= `SIO_RST_OFF;
    end else if (wr_psrc1) begin
      psrc1_r <= reg_wdata;
    end
  end

  // ------------------------------------------------------------
  // control and interrupt mask
  // ------------------------------------------------------------

  // control; restart bit lasts one cycle so a stuck write cannot mask faults
  always @(posedge clock) begin
    if (!resetn) begin
      ctrl_r <= `SIO_RST_CTRL;
    end else if (wr_ctrl) begin
      ctrl_r <= reg_wdata & `SIO_CTRL_WMASK; // upper bits ignored
    end else begin
      ctrl_r[`SIO_C_RESTART] <= 1'b0;
    end
  end

  // interrupt mask, same layout as status
  always @(posedge clock) begin
    if (!resetn) begin
      mask_r <= `SIO_RST_MASK;
    end else if (wr_mask) begin
      mask_r <= reg_wdata;
    end
  end

  // ------------------------------------------------------------
  // source decode
  // ------------------------------------------------------------
  function sel_src;
    input [7:0] code;
    input [64:0] fn;
    input [1:0] rack;
    begin
      if (code == `SIO_SRC_ON)
        sel_src = 1'b1;
      else if (code == `SIO_SRC_READY)
        sel_src = 1'b1;
      else if (code == `SIO_SRC_RACK1)
        sel_src = rack[0];
      else if (code == `SIO_SRC_RACK2)
        sel_src = rack[1];
      else if (code != `SIO_SRC_OFF && code <= `SIO_SRC_FN_LAST)
        sel_src = fn[code[6:0]];
      else
        sel_src = 1'b0; // off and unassigned codes
    end
  endfunction

  // pairing enables
  wire opair0 = ctrl_r[`SIO_C_OPAIR0];
  wire opair1 = ctrl_r[`SIO_C_OPAIR1];
  wire ipair0 = ctrl_r[`SIO_C_IPAIR0];
  wire ipair1 = ctrl_r[`SIO_C_IPAIR1];
  // levels named by the pair and single codes
  wire p0_lvl = sel_src(psrc0_r, fn_r, rack_r);
  wire p1_lvl = sel_src(psrc1_r, fn_r, rack_r);
  wire s0_lvl = sel_src(src0_r, fn_r, rack_r);
  wire s1_lvl = sel_src(src1_r, fn_r, rack_r);
  wire s2_lvl = sel_src(src2_r, fn_r, rack_r);
  wire s3_lvl = sel_src(src3_r, fn_r, rack_r);
  reg [3:0] out_nxt;

  // pair code overrides single codes of both pair members
  always @* begin
    out_nxt[0] = opair0 ? p0_lvl : s0_lvl;
    out_nxt[1] = opair0 ? p0_lvl : s1_lvl;
    out_nxt[2] = opair1 ? p1_lvl : s2_lvl;
    out_nxt[3] = opair1 ? p1_lvl : s3_lvl;
    if (io_failure) begin
      out_nxt = 4'h0; // safe state drops all outputs
    end
  end

  // ------------------------------------------------------------
  // discrepancy supervision
  // ------------------------------------------------------------
  reg [31:0] disc0_r;
  reg [31:0] disc1_r;
  reg [1:0] pair_lvl_r;
  wire diff0 = ipair0 && (in_r[0] != in_r[1]);
  wire diff1 = ipair1 && (in_r[2] != in_r[3]);

  // pair 1+2 split timer, cleared on agreement
  always @(posedge clock) begin
    if (!resetn) begin
      disc0_r <= 32'h0;
    end else if (diff0) begin
      disc0_r <= disc0_r + 32'h1;
    end else begin
      disc0_r <= 32'h0;
    end
  end

  // pair 3+4 split timer, cleared on agreement
  always @(posedge clock) begin
    if (!resetn) begin
      disc1_r <= 32'h0;
    end else if (diff1) begin
      disc1_r <= disc1_r + 32'h1;
    end else begin
      disc1_r <= 32'h0;
    end
  end

  // ------------------------------------------------------------
  // failure events
  // ------------------------------------------------------------

  // one-cycle event when a split outlasts the limit
  always @(posedge clock) begin
    if (!resetn) begin
      fail_evt_r <= 2'h0;
    end else begin
      fail_evt_r[0] <= diff0 && (disc0_r == DISC_CYCLES[31:0]);
      fail_evt_r[1] <= diff1 && (disc1_r == DISC_CYCLES[31:0]);
    end
  end

  // ------------------------------------------------------------
  // pair levels
  // ------------------------------------------------------------

  // pair level follows only when both inputs agree
  always @(posedge clock) begin
    if (!resetn) begin
      pair_lvl_r <= 2'h0;
    end else begin
      if (in_r[0] == in_r[1])
        pair_lvl_r[0] <= in_r[0];
      if (in_r[2] == in_r[3])
        pair_lvl_r[1] <= in_r[2];
    end
  end

  // ------------------------------------------------------------
  // status, interrupt and outputs
  // ------------------------------------------------------------
  // sticky pair failures, set wins over write-one-to-clear
  always @(posedge clock) begin
    if (!resetn) begin
      fail_stat_r <= 2'h0;
    end else begin
      fail_stat_r <= (fail_stat_r & ~stat_clr) | fail_evt_r;
    end
  end

  // safe state, left only when the control restart bit is written
  always @(posedge clock) begin
    if (!resetn) begin
      io_failure <= 1'b0;
    end else if (|fail_evt_r) begin
      io_failure <= 1'b1;
    end else if (ctrl_r[`SIO_C_RESTART]) begin
      io_failure <= 1'b0; // new event beats restart
    end
  end

  // ------------------------------------------------------------
  // terminal drivers
  // ------------------------------------------------------------
  always @(posedge clock) begin
    if (!resetn) begin
      safe_out_pin <= 4'h0;
    end else begin
      safe_out_pin <= out_nxt;
    end
  end

  // ------------------------------------------------------------
  // level interrupt from unmasked status
  // ------------------------------------------------------------
  always @(posedge clock) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(fail_stat_r & mask_r[`SIO_S_FAIL1:`SIO_S_FAIL0]);
    end
  end

  // ------------------------------------------------------------
  // read port
  // ------------------------------------------------------------
  reg [7:0] rdata_nxt;

  // read mux, zero for unmapped addresses and idle cycles
  always @* begin
    rdata_nxt = 8'h0;
    if (reg_rd) begin
      case (reg_addr)
        `SIO_A_SRC0: rdata_nxt = src0_r;
        `SIO_A_SRC1: rdata_nxt = src1_r;
        `SIO_A_SRC2: rdata_nxt = src2_r;
        `SIO_A_SRC3: rdata_nxt = src3_r;
        `SIO_A_PSRC0: rdata_nxt = psrc0_r;
        `SIO_A_PSRC1: rdata_nxt = psrc1_r;
        `SIO_A_CTRL: rdata_nxt = ctrl_r;
        `SIO_A_IN: rdata_nxt = {2'h0, pair_lvl_r, in_r};
        `SIO_A_OUT: rdata_nxt = {2'h0, safe_out_pin[2], safe_out_pin[0], safe_out_pin};
        `SIO_A_STAT: rdata_nxt = {5'h0, io_failure, fail_stat_r};
        `SIO_A_MASK: rdata_nxt = mask_r;
        default: rdata_nxt = 8'h0;
      endcase
    end
  end

  // read data stands one cycle after the strobe
  always @(posedge clock) begin
    if (!resetn) begin
      reg_rdata <= 8'h0;
    end else begin
      reg_rdata <= rdata_nxt;
    end
  end

endmodule
`default_nettype wire

/* File: verilog/sio_defs.vh */
// constants for the safe i/o routing and supervision block
//
// Notes on behaviour
// - single source code picks output driver
// - code 0x43 gives always-on ready
// - codes 0x45/0x46 give restart requests
// - defaults: outputs 1,2,4 on, 3 off
// - settings volatile, reset restores defaults
// - paired output ignores its single code
// - pair level from equal inputs, unequal holds
// - disagreement over 100 ms raises failure
// - paired outputs driven identically
// - readable level for each safe input
// - readable level for each safe output
// - readable combined level per input pair
// - pair code triggers both pair outputs
`ifndef SIO_DEFS_VH
`define SIO_DEFS_VH
// register addresses
`define SIO_A_SRC0 8'h00
`define SIO_A_SRC1 8'h01
`define SIO_A_SRC2 8'h02
`define SIO_A_SRC3 8'h03
`define SIO_A_PSRC0 8'h04
`define SIO_A_PSRC1 8'h05
`define SIO_A_CTRL 8'h06
`define SIO_A_IN 8'h07
`define SIO_A_OUT 8'h08
`define SIO_A_STAT 8'h09
`define SIO_A_MASK 8'h0a
// control fields
`define SIO_C_OPAIR0 0
`define SIO_C_OPAIR1 1
`define SIO_C_IPAIR0 2
`define SIO_C_IPAIR1 3
`define SIO_C_RESTART 4
`define SIO_CTRL_WMASK 8'h1f
// status / level fields
`define SIO_S_FAIL0 0
`define SIO_S_FAIL1 1
`define SIO_L_PAIR0 4
`define SIO_L_PAIR1 5
// source codes
`define SIO_SRC_OFF 8'h00
`define SIO_SRC_FN_LAST 8'h40
`define SIO_SRC_READY 8'h43
`define SIO_SRC_RACK1 8'h45
`define SIO_SRC_RACK2 8'h46
`define SIO_SRC_ON 8'hff
// reset values
`define SIO_RST_ON 8'hff
`define SIO_RST_OFF 8'h00
`define SIO_RST_CTRL 8'h00
`define SIO_RST_MASK 8'h00
// discrepancy time
`define SIO_DISC_MS 100
`define SIO_CLK_KHZ 125000
`endif

/* File: verification/sio_checker.sv */
// port assertions for the safe i/o block
`timescale 1ns/1ps
`default_nettype none
module sio_checker #(parameter integer DISC_CYCLES = 20) (
  // clock, reset, register port
  input wire logic clock,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // terminals and fault
  input wire logic [3:0] safe_in_pin,
  input wire logic [3:0] safe_out_pin,
  input wire logic io_failure,
  input wire logic irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  int split_r;
  logic [3:0] agree_r;
  // run of pair disagreement, kept across short agreement glitches
  always @(posedge clock) begin
    agree_r <= {agree_r[2:0], safe_in_pin[0] == safe_in_pin[1] && safe_in_pin[2] == safe_in_pin[3]};
    if (!resetn || &agree_r)
      split_r <= 0;
    else if (!agree_r[0])
      split_r <= split_r + 1;
  end
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("stray read data");
  a_fail_outs_off: assert property (io_failure |=> safe_out_pin == 4'h0) else $error("outputs on in failure");
  a_fail_release: assert property ($fell(io_failure) |-> $past(reg_wr, 2) && $past(reg_addr, 2) == 8'h06
    && $past(reg_wdata[4], 2)) else $error("failure left without restart");
  a_fail_cause: assert property ($rose(io_failure) |-> split_r >= DISC_CYCLES) else $error("early failure");
  a_irq_cause: assert property ($rose(irq) |-> $past(io_failure) || $past(reg_wr, 2)) else $error("stray irq");
  a_status_read: assert property (reg_rd && reg_addr == 8'h09 |=> reg_rdata[2] == $past(io_failure))
    else $error("status disagrees");
  a_out_read: assert property (reg_rd && reg_addr == 8'h08 |=> reg_rdata[3:0] == $past(safe_out_pin))
    else $error("output levels disagree");
  a_unmapped_zero: assert property (reg_rd && reg_addr > 8'h0a |=> reg_rdata == 8'h00) else $error("unmapped data");
  c_fail: cover property ($rose(io_failure));
  c_restart: cover property ($fell(io_failure));
  c_irq: cover property ($rose(irq));
endmodule
bind sio_top sio_checker #(.DISC_CYCLES(DISC_CYCLES)) chk (.clock(clock), .resetn(resetn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .safe_in_pin(safe_in_pin),
  .safe_out_pin(safe_out_pin), .io_failure(io_failure), .irq(irq));
`default_nettype wire

/* File: verification/sio_field.sv */
// field sensors feeding the safe input terminals
`timescale 1ns/1ps
`default_nettype none
module sio_field (
  // clock and commanded contact levels
  input wire logic clock,
  input wire logic [3:0] want,
  // contacts on the terminals
  output logic [3:0] pin
);
  // contacts settle one cycle after a command, like a relay
  initial pin = 4'h0;
  always @(posedge clock) pin <= want;
endmodule
`default_nettype wire

/* File: verification/tb_sio_top.sv */
// self-checking bench for the safe i/o block
`timescale 1ns/1ps
`default_nettype none
module tb_sio_top;
  localparam integer D = 20;
  logic clock = 0, resetn = 0, reg_wr = 0, reg_rd = 0, io_failure, irq;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
  logic [64:0] func_result = 0;
  logic [1:0] restart_req = 0;
  logic [3:0] want = 0, safe_in_pin, safe_out_pin;
  int mismatches = 0, total_checks = 0, cycles = 0;
  always #4 clock = ~clock;
  sio_top #(.DISC_CYCLES(D)) uut (.clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .func_result(func_result), .restart_req(restart_req),
    .safe_in_pin(safe_in_pin), .safe_out_pin(safe_out_pin), .io_failure(io_failure), .irq(irq));
  sio_field field (.clock(clock), .want(want), .pin(safe_in_pin));
  task automatic chk(input logic [7:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    if (mismatches == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // one-cycle register write and read
  task automatic wr(input logic [7:0] a, d);
    @(posedge clock);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, exp);
    @(posedge clock);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'h0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic do_reset;
    resetn <= 1'h0;
    tick(3);
    resetn <= 1'h1;
    tick(3);
  endtask
  // a changed code must not survive a reset
  task automatic t_defaults;
    wr(8'h02, 8'hff);
    do_reset;
    rd(8'h00, 8'hff);
    rd(8'h02, 8'h00);
    rd(8'h04, 8'h00);
    rd(8'h0b, 8'h00);
    chk({4'h0, safe_out_pin}, 8'h0b);
  endtask
  // nine codes, first with only restart request 1 set, then with request 2 and function results 1 and 64
  task automatic t_codes;
    logic [7:0] code [9] = '{8'h00, 8'hff, 8'h43, 8'h45, 8'h46, 8'h40, 8'h01, 8'h02, 8'h41};
    logic [8:0] exp [2] = '{9'h00e, 9'h076};
    for (int p = 0; p < 2; p++) begin
      func_result <= p ? {1'h1, 62'h0, 2'h2} : 65'h0;
      restart_req <= p ? 2'h2 : 2'h1;
      for (int i = 0; i < 9; i++) begin
        wr(8'h00, code[i]);
        tick(4);
        chk({7'h0, safe_out_pin[0]}, {7'h0, exp[p][i]});
      end
    end
  endtask
  // pair code overrides opposite single codes
  task automatic t_out_pair;
    wr(8'h00, 8'h00);
    wr(8'h01, 8'hff);
    wr(8'h04, 8'h43);
    wr(8'h06, 8'h01);
    tick(2);
    chk({6'h0, safe_out_pin[1:0]}, 8'h03);
    rd(8'h08, 8'h1b);
    wr(8'h04, 8'h00);
    tick(2);
    chk({6'h0, safe_out_pin[1:0]}, 8'h00);
    wr(8'h06, 8'h04);
  endtask
  task automatic t_inputs;
    want <= 4'h3;
    tick(5);
    rd(8'h07, 8'h13);
    want <= 4'h0;
    tick(5);
    rd(8'h07, 8'h00);
  endtask
  // a short split restarts the timer, a long one trips
  task automatic t_disc;
    wr(8'h0a, 8'h01);
    want <= 4'h1;
    tick(D - 5);
    want <= 4'h3;
    tick(5);
    want <= 4'h1;
    tick(D - 5);
    chk({7'h0, io_failure}, 8'h00);
    tick(15);
    chk({6'h0, io_failure, irq}, 8'h03);
    chk({4'h0, safe_out_pin}, 8'h00);
    want <= 4'h3;
    tick(5);
    rd(8'h09, 8'h05);
    wr(8'h09, 8'h01);
    wr(8'h06, 8'h14);
    tick(3);
    chk({6'h0, io_failure, irq}, 8'h00);
    chk({4'h0, safe_out_pin}, 8'h0a);
    rd(8'h06, 8'h04);
    rd(8'h0a, 8'h01);
  endtask
  initial begin
    do_reset;
    t_defaults;
    t_codes;
    t_out_pair;
    t_inputs;
    t_disc;
    give_verdict;
  end
  // hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles > 3000) begin
      mismatches++;
      give_verdict;
    end
  end
endmodule
`default_nettype wire
